//--- common/tarp_regs.svh
// offsets, field positions, reset values and timing counts
`ifndef TARP_REGS_SVH
`define TARP_REGS_SVH
`define TARP_OFF_FILLED       12'h334
`define TARP_OFF_TIMEOUT      12'h338
`define TARP_OFF_MEMPTR       12'h33c
`define TARP_OFF_IRQ_STATUS   12'h350
`define TARP_OFF_IRQ_CLEAR    12'h358
`define TARP_OFF_IRQ_ENABLE   12'h35c
`define TARP_OFF_SWRESET      12'h30c
`define TARP_BIT_ASYNC_FILL   0
`define TARP_BIT_INT_FILL     1
`define TARP_BIT_ISO_FILL     2
`define TARP_BIT_RESET_ALL    0
`define TARP_MSB_BANK         17
`define TARP_LSB_BANK         16
`define TARP_MSB_START        15
`define TARP_RST_VALUE        32'h0000_0000
`define TARP_CLK_MHZ          100
`define TARP_MS_US            1000
`define TARP_MS_CYCLES        (`TARP_CLK_MHZ * `TARP_MS_US)
`define TARP_BYTES_PER_READ   16'h0004
`define TARP_IRQ_TIMEOUT      0
`define TARP_IRQ_PTR_WRAP     1
`endif

//--- common/tarp_pkg.sv
// types shared by the register bank
package tarp_pkg;
	typedef enum logic [1:0] {
		TARP_AREA_ISO,
		TARP_AREA_INT,
		TARP_AREA_ASYNC,
		TARP_AREA_IDLE
	} tarp_area_t;
	typedef enum logic [1:0] {
		TARP_TMO_IDLE,
		TARP_TMO_RUN,
		TARP_TMO_DONE
	} tarp_tmo_state_t;
endpackage : tarp_pkg

//--- verilog/tarp_bank_ptr.sv
// one auto-incrementing bank read pointer
`timescale 1ns/100ps
`include "tarp_regs.svh"
module tarp_bank_ptr (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_soft_clr,
	// control
	input  wire logic        i_load,
	input  wire logic [15:0] i_start,
	input  wire logic        i_advance,
	// state
	output logic      [15:0] o_ptr,
	output logic             o_wrap
);
	logic [15:0] ptr_q;
	logic [15:0] ptr_d;
	assign ptr_d  = ptr_q + `TARP_BYTES_PER_READ;
	assign o_ptr  = ptr_q;
	assign o_wrap = i_advance && !i_load && (ptr_d < ptr_q);
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ptr_q <= 16'h0000;
		end else if (i_ce) begin
			if (i_soft_clr) begin
				ptr_q <= 16'h0000;
			end else if (i_load) begin
				ptr_q <= i_start;
			end else if (i_advance) begin
				ptr_q <= ptr_d;
			end
		end
	end
endmodule : tarp_bank_ptr

//--- verilog/tarp_ms_timer.sv
// millisecond timeout counter for completed async descriptors
`timescale 1ns/100ps
`include "tarp_regs.svh"
module tarp_ms_timer #(
	parameter int unsigned MS_CYCLES = `TARP_MS_CYCLES
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_soft_clr,
	// control
	input  wire logic [31:0] i_limit_ms,
	input  wire logic        i_async_done,
	// result
	output logic             o_expired
);
	tarp_pkg::tarp_tmo_state_t st_q;
	logic [31:0] tick_q;
	logic [31:0] ms_q;
	logic        tick_end;
	assign tick_end  = (tick_q == MS_CYCLES - 1);
	assign o_expired = (st_q == tarp_pkg::TARP_TMO_DONE);
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_q   <= tarp_pkg::TARP_TMO_IDLE;
			tick_q <= 32'h0000_0000;
			ms_q   <= 32'h0000_0000;
		end else if (i_ce) begin
			if (i_soft_clr) begin
				st_q   <= tarp_pkg::TARP_TMO_IDLE;
				tick_q <= 32'h0000_0000;
				ms_q   <= 32'h0000_0000;
			end else begin
				case (st_q)
				tarp_pkg::TARP_TMO_IDLE: begin
					tick_q <= 32'h0000_0000;
					ms_q   <= 32'h0000_0000;
					if (i_async_done && i_limit_ms != 32'h0000_0000) begin
						st_q <= tarp_pkg::TARP_TMO_RUN;
					end
				end
				tarp_pkg::TARP_TMO_RUN: begin
					tick_q <= tick_end ? 32'h0000_0000 : tick_q + 32'h0000_0001;
					if (i_limit_ms == 32'h0000_0000) begin
						st_q <= tarp_pkg::TARP_TMO_IDLE;
					end else if (tick_end) begin
						ms_q <= ms_q + 32'h0000_0001;
						if (ms_q + 32'h0000_0001 >= i_limit_ms) begin
							st_q <= tarp_pkg::TARP_TMO_DONE;
						end
					end
				end
				tarp_pkg::TARP_TMO_DONE: begin
					st_q <= tarp_pkg::TARP_TMO_IDLE;
				end
				default: begin
					st_q <= tarp_pkg::TARP_TMO_IDLE;
				end
				endcase
			end
		end
	end
endmodule : tarp_ms_timer

//--- verilog/tarp_regbank.sv
// transfer area flags, async done timeout and bank read pointers
// Function
// - filled area gets its descriptor headers walked
// - bit 2 gates isochronous area
// - bit 1 gates interrupt area
// - bit 0 gates asynchronous area
// - 32-bit ms timeout raises enabled interrupt
// - timeout applies to async done only
// - pointer write latches start for bank
// - each bank read advances that pointer
// - bits 17:16 select one of four banks
// - bits 15:0 hold start address
// - software reset clears all registers
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`include "tarp_regs.svh"
module tarp_regbank #(
	parameter int unsigned MS_CYCLES = `TARP_MS_CYCLES
) (
	// clock, reset, enable
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [11:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// memory read port
	input  wire logic        i_mem_rd,
	input  wire logic [1:0]  i_mem_bank,
	output logic      [15:0] o_mem_addr,
	// scheduler side
	input  wire logic        i_async_done,
	input  wire logic        i_sched_start,
	output logic             o_walk_iso,
	output logic             o_walk_int,
	output logic             o_walk_async,
	// interrupt
	output logic             o_irq
);
	logic [2:0]  fill_q;
	logic [31:0] tmo_q;
	logic [17:0] memreg_q;
	logic [1:0]  irq_sta_q;
	logic [1:0]  irq_en_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        soft_clr_q;
	logic [15:0] ptr [4];
	logic [3:0]  wrap;
	logic        expired;
	logic        req;
	logic        wr;
	logic        rd;
	logic        full_wr;
	logic        hit_fill;
	logic        hit_tmo;
	logic        hit_mem;
	logic        hit_sta;
	logic        hit_clr;
	logic        hit_en;
	logic        hit_rst;
	logic        mapped;
	logic [31:0] rmux;
	logic [1:0]  ev;

	assign req      = i_wb_cyc && i_wb_stb && !ack_q;
	assign wr       = req && i_wb_we && i_ce;
	assign rd       = req && !i_wb_we;
	assign full_wr  = wr && (i_wb_sel == 4'hf);
	assign hit_fill = (i_wb_adr == `TARP_OFF_FILLED);
	assign hit_tmo  = (i_wb_adr == `TARP_OFF_TIMEOUT);
	assign hit_mem  = (i_wb_adr == `TARP_OFF_MEMPTR);
	assign hit_sta  = (i_wb_adr == `TARP_OFF_IRQ_STATUS);
	assign hit_clr  = (i_wb_adr == `TARP_OFF_IRQ_CLEAR);
	assign hit_en   = (i_wb_adr == `TARP_OFF_IRQ_ENABLE);
	assign hit_rst  = (i_wb_adr == `TARP_OFF_SWRESET);
	assign mapped   = hit_fill | hit_tmo | hit_mem | hit_sta | hit_en;
	assign rmux = hit_fill ? {29'h0, fill_q} :
		hit_tmo ? tmo_q :
		hit_mem ? {14'h0, memreg_q} :
		hit_sta ? {30'h0, irq_sta_q} :
		hit_en  ? {30'h0, irq_en_q} : 32'h0000_0000;
	assign ev = {|wrap, expired};

	// area walk enables follow the filled flags
	assign o_walk_iso   = i_sched_start && fill_q[`TARP_BIT_ISO_FILL];
	assign o_walk_int   = i_sched_start && fill_q[`TARP_BIT_INT_FILL];
	assign o_walk_async = i_sched_start && fill_q[`TARP_BIT_ASYNC_FILL];
	assign o_irq        = |(irq_sta_q & irq_en_q);
	assign o_wb_ack     = ack_q;
	assign o_wb_dat     = rdat_q;
	assign o_mem_addr   = ptr[i_mem_bank];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_bank
			localparam logic [1:0] BANK_ID = 2'(g);
			tarp_bank_ptr u_ptr (
				.i_clk_sys  (i_clk_sys),
				.i_rst      (i_rst),
				.i_ce       (i_ce),
				.i_soft_clr (soft_clr_q),
				.i_load     (full_wr && hit_mem &&
					i_wb_dat[`TARP_MSB_BANK:`TARP_LSB_BANK] == BANK_ID),
				.i_start    (i_wb_dat[`TARP_MSB_START:0]),
				.i_advance  (i_mem_rd && i_mem_bank == BANK_ID),
				.o_ptr      (ptr[g]),
				.o_wrap     (wrap[g])
			);
		end
	endgenerate

	tarp_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_tmr (
		.i_clk_sys    (i_clk_sys),
		.i_rst        (i_rst),
		.i_ce         (i_ce),
		.i_soft_clr   (soft_clr_q),
		.i_limit_ms   (tmo_q),
		.i_async_done (i_async_done),
		.o_expired    (expired)
	);

	// bus answer: one ack with one wait state, read data registered
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (i_ce) begin
			ack_q  <= req;
			rdat_q <= (rd && mapped) ? rmux : 32'h0000_0000;
		end
	end

	// software reset pulse
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			soft_clr_q <= 1'b0;
		end else if (i_ce) begin
			soft_clr_q <= wr && hit_rst && i_wb_sel[0] &&
				i_wb_dat[`TARP_BIT_RESET_ALL];
		end
	end

	// configuration registers
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			fill_q   <= 3'h0;
			tmo_q    <= `TARP_RST_VALUE;
			memreg_q <= 18'h00000;
			irq_en_q <= 2'h0;
		end else if (i_ce) begin
			if (soft_clr_q) begin
				fill_q   <= 3'h0;
				tmo_q    <= `TARP_RST_VALUE;
				memreg_q <= 18'h00000;
				irq_en_q <= 2'h0;
			end else begin
				if (wr && hit_fill && i_wb_sel[0]) begin
					fill_q <= i_wb_dat[2:0];
				end
				if (full_wr && hit_tmo) begin
					tmo_q <= i_wb_dat;
				end
				if (full_wr && hit_mem) begin
					memreg_q <= i_wb_dat[17:0];
				end
				if (wr && hit_en && i_wb_sel[0]) begin
					irq_en_q <= i_wb_dat[1:0];
				end
			end
		end
	end

	// sticky status: set wins over clear
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			irq_sta_q <= 2'h0;
		end else if (i_ce) begin
			if (soft_clr_q) begin
				irq_sta_q <= 2'h0;
			end else if (wr && hit_clr && i_wb_sel[0]) begin
				irq_sta_q <= (irq_sta_q & ~i_wb_dat[1:0]) | ev;
			end else begin
				irq_sta_q <= irq_sta_q | ev;
			end
		end
	end

	property p_fill_gate;
		@(posedge i_clk_sys) disable iff (i_rst)
		!fill_q[`TARP_BIT_ISO_FILL] |-> !o_walk_iso;
	endproperty
	a_fill_gate: assert property (p_fill_gate)
		else $error("iso walked while flag clear");
	property p_int_gate;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_sched_start && fill_q[`TARP_BIT_INT_FILL] |-> o_walk_int;
	endproperty
	a_int_gate: assert property (p_int_gate)
		else $error("int area not walked");
	property p_async_gate;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_walk_async |-> fill_q[`TARP_BIT_ASYNC_FILL] && i_sched_start;
	endproperty
	a_async_gate: assert property (p_async_gate)
		else $error("async walked without flag");
	property p_tmo_irq;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && expired && irq_en_q[`TARP_IRQ_TIMEOUT] && !soft_clr_q
			|=> o_irq;
	endproperty
	a_tmo_irq: assert property (p_tmo_irq)
		else $error("timeout did not raise irq");
	property p_ptr_load;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && full_wr && hit_mem && !soft_clr_q |=>
			ptr[$past(i_wb_dat[17:16])] == $past(i_wb_dat[15:0]);
	endproperty
	a_ptr_load: assert property (p_ptr_load)
		else $error("bank pointer not loaded");
	property p_ptr_step;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && i_mem_rd && !soft_clr_q && !(full_wr && hit_mem) |=>
			ptr[$past(i_mem_bank)] ==
			$past(o_mem_addr) + `TARP_BYTES_PER_READ;
	endproperty
	a_ptr_step: assert property (p_ptr_step)
		else $error("pointer did not advance by one access");
	property p_swreset;
		@(posedge i_clk_sys) disable iff (i_rst)
		soft_clr_q && i_ce |=> fill_q == 3'h0 && tmo_q == 32'h0 && !o_irq;
	endproperty
	a_swreset: assert property (p_swreset)
		else $error("software reset left state");
	property p_ack_once;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_wb_ack && i_ce |=> !o_wb_ack;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack held two cycles");
	property p_no_done_no_run;
		@(posedge i_clk_sys) disable iff (i_rst)
		tmo_q == 32'h0 |-> !expired;
	endproperty
	a_no_done_no_run: assert property (p_no_done_no_run)
		else $error("timer expired with zero limit");
	property p_walk_idle;
		@(posedge i_clk_sys) disable iff (i_rst)
		!i_sched_start |-> !o_walk_iso && !o_walk_int && !o_walk_async;
	endproperty
	a_walk_idle: assert property (p_walk_idle)
		else $error("area walked without a scheduler pass");
	property p_int_clear;
		@(posedge i_clk_sys) disable iff (i_rst)
		!fill_q[`TARP_BIT_INT_FILL] |-> !o_walk_int;
	endproperty
	a_int_clear: assert property (p_int_clear)
		else $error("int area walked while flag clear");
	property p_ptr_hold;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && !i_mem_rd && !soft_clr_q && !(full_wr && hit_mem) |=>
			ptr[$past(i_mem_bank)] == $past(o_mem_addr);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("pointer moved without a read");
	property p_swreset_ptr;
		@(posedge i_clk_sys) disable iff (i_rst)
		soft_clr_q && i_ce |=> o_mem_addr == 16'h0000 &&
			memreg_q == 18'h00000 && irq_en_q == 2'h0;
	endproperty
	a_swreset_ptr: assert property (p_swreset_ptr)
		else $error("software reset left pointer state");
	property p_sta_sticky;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && irq_sta_q[`TARP_IRQ_TIMEOUT] && !soft_clr_q &&
			!(wr && hit_clr && i_wb_sel[0] && i_wb_dat[`TARP_IRQ_TIMEOUT])
			|=> irq_sta_q[`TARP_IRQ_TIMEOUT];
	endproperty
	a_sta_sticky: assert property (p_sta_sticky)
		else $error("timeout status lost without clear");
	property p_fill_write;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && wr && hit_fill && i_wb_sel[0] && !soft_clr_q |=>
			fill_q == $past(i_wb_dat[2:0]);
	endproperty
	a_fill_write: assert property (p_fill_write)
		else $error("filled flags not written");
	c_walk: cover property (@(posedge i_clk_sys) o_walk_async && o_walk_iso);
	c_irq: cover property (@(posedge i_clk_sys) o_irq);
	c_step: cover property (@(posedge i_clk_sys) i_mem_rd ##1 i_mem_rd);
	c_swreset: cover property (@(posedge i_clk_sys) soft_clr_q);
	c_wrap: cover property (@(posedge i_clk_sys) i_ce && |wrap);
endmodule : tarp_regbank

//--- verification/tarp_host_model.sv
// wishbone master standing in for the host processor
`timescale 1ns/100ps
module tarp_host_model (
	// clock
	input  wire logic        i_clk_sys,
	// bus request
	output logic             o_cyc,
	output logic             o_stb,
	output logic             o_we,
	output logic      [11:0] o_adr,
	output logic      [3:0]  o_sel,
	output logic      [31:0] o_dat,
	// bus answer
	input  wire logic        i_ack,
	input  wire logic [31:0] i_dat
);
	initial begin
		o_cyc = 1'b0;
		o_stb = 1'b0;
		o_we  = 1'b0;
		o_adr = 12'h000;
		o_sel = 4'h0;
		o_dat = 32'h0000_0000;
	end

	// one classic cycle; request held until the ack edge
	task automatic xfer(input logic we, input logic [11:0] a,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk_sys);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we  <= we;
		o_adr <= a;
		o_sel <= 4'hf;
		o_dat <= d;
		// only the bench watchdog ends a wait for ack
		do begin
			@(posedge i_clk_sys);
		end while (i_ack !== 1'b1);
		q = i_dat;
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		o_we  <= 1'b0;
		// released data no longer shows the last value
		o_dat <= ~d;
	endtask : xfer
endmodule : tarp_host_model

//--- verification/tb_tarp_regbank.sv
// self-checking bench of the register bank
`timescale 1ns/100ps
`include "tarp_regs.svh"
module tb_tarp_regbank;
	logic        i_clk_sys, i_rst, i_ce, cyc, stb, we, ack, mem_rd;
	logic        done, start, wiso, wint, wasy, irq;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [1:0]  bank;
	logic [15:0] maddr;
	int          fails, samples_checked, n;
	// filled flags beside the walks they should open
	logic [5:0]  rows [5] = '{6'h00, 6'h09, 6'h12, 6'h24, 6'h3f};

	tarp_host_model host (.i_clk_sys(i_clk_sys), .o_cyc(cyc), .o_stb(stb),
		.o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat), .i_ack(ack),
		.i_dat(rdat));
	tarp_regbank #(.MS_CYCLES(10)) DUT (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .i_ce(i_ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_mem_rd(mem_rd),
		.i_mem_bank(bank), .o_mem_addr(maddr), .i_async_done(done),
		.i_sched_start(start), .o_walk_iso(wiso), .o_walk_int(wint),
		.o_walk_async(wasy), .o_irq(irq));

	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		host.xfer(1'b0, a, 32'h0000_0000, q);
	endtask : rd

	task automatic pulse_rd();
		@(posedge i_clk_sys) mem_rd <= 1'b1;
		@(posedge i_clk_sys) mem_rd <= 1'b0;
		@(posedge i_clk_sys) #1;
	endtask : pulse_rd

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	initial begin
		#50000;
		fails++;
		end_of_test();
	end

	initial begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		mem_rd = 1'b0;
		done = 1'b0;
		start = 1'b0;
		bank = 2'h0;
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rd(`TARP_OFF_TIMEOUT);
		check(q, `TARP_RST_VALUE);
		$display("reset value test done");
		start <= 1'b1;
		foreach (rows[i]) begin
			wr(`TARP_OFF_FILLED, {29'h0, rows[i][5:3]});
			#1 check({29'h0, wiso, wint, wasy}, {29'h0, rows[i][2:0]});
			rd(`TARP_OFF_FILLED);
			check(q, {29'h0, rows[i][5:3]});
		end
		$display("flags test done");
		bank <= 2'h2;
		wr(`TARP_OFF_MEMPTR, {14'h0, 2'h2, 16'h1230});
		@(posedge i_clk_sys) #1 check({16'h0, maddr}, 32'h1230);
		pulse_rd();
		pulse_rd();
		check({16'h0, maddr}, 32'h1238);
		@(posedge i_clk_sys) bank <= 2'h1;
		#1 check({16'h0, maddr}, 32'h0000);
		@(posedge i_clk_sys) bank <= 2'h2;
		wr(`TARP_OFF_MEMPTR, {14'h0, 2'h2, 16'hfffc});
		pulse_rd();
		check({16'h0, maddr}, 32'h0000);
		$display("pointer test done");
		wr(`TARP_OFF_TIMEOUT, 32'h0000_0002);
		wr(`TARP_OFF_IRQ_ENABLE, 32'h0000_0001);
		@(posedge i_clk_sys) done <= 1'b1;
		@(posedge i_clk_sys) done <= 1'b0;
		n = 1;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge i_clk_sys) #1;
			n++;
		end
		check({31'h0, n >= 18 && n <= 22}, 32'h1);
		rd(`TARP_OFF_IRQ_STATUS);
		check(q, 32'h0000_0003);
		wr(`TARP_OFF_IRQ_ENABLE, 32'h0000_0000);
		@(posedge i_clk_sys) #1 check({31'h0, irq}, 32'h0);
		wr(`TARP_OFF_IRQ_ENABLE, 32'h0000_0001);
		wr(`TARP_OFF_IRQ_CLEAR, 32'h0000_0001);
		@(posedge i_clk_sys) #1 check({31'h0, irq}, 32'h0);
		rd(12'h3f0);
		check(q, 32'h0000_0000);
		$display("timeout test done");
		wr(`TARP_OFF_SWRESET, 32'h0000_0001);
		@(posedge i_clk_sys);
		rd(`TARP_OFF_TIMEOUT);
		check(q, `TARP_RST_VALUE);
		rd(`TARP_OFF_MEMPTR);
		check(q, `TARP_RST_VALUE);
		#1 check({29'h0, wiso, wint, wasy}, 32'h0);
		$display("software reset test done");
		@(posedge i_clk_sys) i_ce <= 1'b0;
		pulse_rd();
		check({16'h0, maddr}, 32'h0000);
		@(posedge i_clk_sys) i_ce <= 1'b1;
		pulse_rd();
		check({16'h0, maddr}, 32'h0004);
		$display("clock enable test done");
		wr(`TARP_OFF_FILLED, 32'h0000_0007);
		@(posedge i_clk_sys) i_rst <= 1'b1;
		@(posedge i_clk_sys) i_rst <= 1'b0;
		#1 check({29'h0, wiso, wint, wasy}, 32'h0);
		check({16'h0, maddr}, 32'h0000);
		rd(`TARP_OFF_FILLED);
		check(q, `TARP_RST_VALUE);
		$display("hardware reset test done");
		end_of_test();
	end
endmodule : tb_tarp_regbank
